/* File: verilog/afe_gain_filter_adc_control.sv */
// Function
// - Gain code bits 5:4 pick coarse stage, -12 to +6 dB, 6 dB steps.
// - Gain code bits 3:0 pick 16 linear fine steps; gain 0.25*2^c*(1+f/16).
// - Boost bit set adds a further 12 dB gain on that channel.
// - Auto gain by default; manual needs gain field written and auto cleared.
// - Half-bandwidth bit set halves that channel's anti-alias filter bandwidth.
// - Bypass bit set routes that channel around the anti-alias filter.
// - Without dual mode, second converter samples channel 2 or 3 by select.
// - Dual mode makes second converter alternate channels 2 and 3 per sample.
// - Converter sample clock is five times the crystal clock via DLL.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "afe_ctrl_defs.svh"

module afe_gain_filter_adc_control
    import afe_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [15:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [15:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic [2:0][5:0] autoGainCode,
    input wire logic sampleTick,
    output chan_ctrl_t [2:0] chanCtrl,
    output logic adc2ChanSel,
    output logic [2:0] dllMultFactor
);

    // ------------------------------------------------------------
    // Reset image
    // ------------------------------------------------------------
    // Channel word at reset: code zero with its matching quarter gain, so the
    // gain checks see a consistent word on the first edge after release
    localparam chan_ctrl_t CHAN_RESET = '{
        boost: 1'b0,
        halfBw: 1'b0,
        bypass: 1'b0,
        gainCode: 6'h00,
        gainLinear: `AFE_FINE_BASE
    };

    localparam afe_state_t STATE_RESET = '{
        misc: `AFE_MISC_RESET,
        ctl1: `AFE_CTL1_RESET,
        ctl3: `AFE_CTL3_RESET,
        gain: `AFE_GAIN_RESET,
        dfe: `AFE_DFE_RESET,
        awHeld: 1'b0,
        wHeld: 1'b0,
        awAddr: 16'h0000,
        wByte: 8'h00,
        wLane: 1'b0,
        awReady: 1'b1,
        wReady: 1'b1,
        bValid: 1'b0,
        bResp: RESP_OKAY,
        arReady: 1'b1,
        rValid: 1'b0,
        rResp: RESP_OKAY,
        rData: 32'h0000_0000,
        adc2Chan: 1'b0,
        chan: {3{CHAN_RESET}},
        dllMult: `AFE_DLL_MULT
    };

    afe_state_t state_reg;
    afe_state_t state_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address decode shared by the read and write paths
    function automatic reg_sel_t decodeSel(input logic [15:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'b00) begin
            case (addr[15:2])
                `AFE_IDX_MISC: sel = SEL_MISC;
                `AFE_IDX_CTL1: sel = SEL_CTL1;
                `AFE_IDX_CTL3: sel = SEL_CTL3;
                `AFE_IDX_GAIN: sel = SEL_GAIN;
                `AFE_IDX_STATUS: sel = SEL_STATUS;
                `AFE_IDX_DFE: sel = SEL_DFE;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // Read mux; status shows the live gain and converter routing
    function automatic logic [7:0] regRead(input reg_sel_t sel, input afe_state_t s);
        logic [7:0] val;
        val = 8'h00;
        case (sel)
            SEL_MISC: val = s.misc;
            SEL_CTL1: val = s.ctl1;
            SEL_CTL3: val = s.ctl3;
            SEL_GAIN: val = s.gain;
            SEL_DFE: val = s.dfe;
            SEL_STATUS: val = {s.misc[`AFE_MISC_DUAL_BIT], s.adc2Chan, s.chan[0].gainCode};
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // Linear gain in 1/64 units: (16 + fine) << coarse, four times more when boosted
    function automatic logic [9:0] linGain(input logic [5:0] code, input logic boost);
        logic [9:0] base;
        base = `AFE_FINE_BASE + {6'h00, code[3:0]};
        base = base << code[5:4];
        if (boost) begin
            base = base << `AFE_BOOST_SHIFT;
        end
        return base;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus slave, register file and channel control in one pass
    always_comb begin
        reg_sel_t wSel;
        reg_sel_t rSel;
        logic [5:0] code;
        wSel = SEL_NONE;
        rSel = SEL_NONE;
        code = 6'h00;
        state_next = state_reg;

        // Address and data may arrive in either order
        if (awvalid && state_reg.awReady) begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = awaddr;
        end
        if (wvalid && state_reg.wReady) begin
            state_next.wHeld = 1'b1;
            state_next.wByte = wdata[7:0];
            state_next.wLane = wstrb[0];
        end
        if (state_reg.bValid && bready) begin
            state_next.bValid = 1'b0;
        end

        // Commit once both halves are held; only the low byte lane matters
        if (state_reg.awHeld && state_reg.wHeld && !state_reg.bValid) begin
            wSel = decodeSel(state_reg.awAddr);
            state_next.bResp = (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (state_reg.wLane) begin
                case (wSel)
                    SEL_MISC: state_next.misc = state_reg.wByte & `AFE_MISC_MASK;
                    SEL_CTL1: state_next.ctl1 = state_reg.wByte & `AFE_CTL1_MASK;
                    SEL_CTL3: state_next.ctl3 = state_reg.wByte & `AFE_CTL3_MASK;
                    // stored even while auto gain runs
                    SEL_GAIN: state_next.gain = state_reg.wByte & `AFE_GAIN_MASK;
                    SEL_DFE: state_next.dfe = state_reg.wByte & `AFE_DFE_MASK;
                    default: state_next.gain = state_next.gain;
                endcase
            end
            state_next.awHeld = 1'b0;
            state_next.wHeld = 1'b0;
            state_next.bValid = 1'b1;
        end
        // Stall new writes until the response has gone
        state_next.awReady = !state_next.awHeld && !state_next.bValid;
        state_next.wReady = !state_next.wHeld && !state_next.bValid;

        // Reads answer on the edge that takes the address
        if (state_reg.rValid && rready) begin
            state_next.rValid = 1'b0;
        end
        if (arvalid && state_reg.arReady) begin
            rSel = decodeSel(araddr);
            state_next.rValid = 1'b1;
            state_next.rData = {24'h00_0000, regRead(rSel, state_reg)};
            state_next.rResp = (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        state_next.arReady = !state_next.rValid;

        // Per-channel amplifier and filter controls
        for (int ch = 0; ch < 3; ch++) begin
            // auto gain unless software cleared the enable
            // manual field ignored while auto runs
            if (state_reg.dfe[`AFE_DFE_AUTO_BIT]) begin
                code = autoGainCode[ch];
            end else begin
                code = state_reg.gain[5:0];
            end
            state_next.chan[ch].boost = state_reg.ctl1[`AFE_CTL1_BOOST_LSB + ch];
            state_next.chan[ch].halfBw = state_reg.ctl1[`AFE_CTL1_HALFBW_LSB + ch];
            state_next.chan[ch].bypass = state_reg.ctl3[`AFE_CTL3_BYPASS_LSB + ch];
            state_next.chan[ch].gainCode = code;
            state_next.chan[ch].gainLinear =
                linGain(code, state_reg.ctl1[`AFE_CTL1_BOOST_LSB + ch]);
        end

        // alternate channel on every sample in dual mode
        if (state_reg.misc[`AFE_MISC_DUAL_BIT]) begin
            if (sampleTick) begin
                state_next.adc2Chan = !state_reg.adc2Chan;
            end
        end else begin
            state_next.adc2Chan = state_reg.misc[`AFE_MISC_CHSEL_BIT];
        end

        // multiplier factor for the sample clock DLL
        state_next.dllMult = `AFE_DLL_MULT;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Async reset loads constants only
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All outputs straight from the state register
    assign awready = state_reg.awReady;
    assign wready = state_reg.wReady;
    assign bvalid = state_reg.bValid;
    assign bresp = state_reg.bResp;
    assign arready = state_reg.arReady;
    assign rvalid = state_reg.rValid;
    assign rdata = state_reg.rData;
    assign rresp = state_reg.rResp;
    assign chanCtrl = state_reg.chan;
    assign adc2ChanSel = state_reg.adc2Chan;
    assign dllMultFactor = state_reg.dllMult;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // Dual mode held across a sample
    sequence dualTick_s;
        state_reg.misc[`AFE_MISC_DUAL_BIT] && sampleTick;
    endsequence

    // Dual mode held with no sample
    sequence dualIdle_s;
        state_reg.misc[`AFE_MISC_DUAL_BIT] && !sampleTick;
    endsequence

    // Static mode settled for two cycles
    sequence staticMode_s;
        !state_reg.misc[`AFE_MISC_DUAL_BIT] [*2];
    endsequence

    coarse_double_a: assert property (
        (chanCtrl[0].gainCode[3:0] == 4'h0 && !chanCtrl[0].boost)
            |-> chanCtrl[0].gainLinear == (10'h010 << chanCtrl[0].gainCode[5:4]))
        else $error("coarse step does not double the gain");

    fine_step_a: assert property (
        !chanCtrl[1].boost |-> chanCtrl[1].gainLinear ==
            ((10'h010 + {6'h00, chanCtrl[1].gainCode[3:0]}) << chanCtrl[1].gainCode[5:4]))
        else $error("fine step gain wrong");

    boost_gain_a: assert property (
        chanCtrl[2].boost |-> chanCtrl[2].gainLinear ==
            (((10'h010 + {6'h00, chanCtrl[2].gainCode[3:0]})
              << chanCtrl[2].gainCode[5:4]) << 2))
        else $error("boost does not add 12 dB");

    manual_gain_a: assert property (
        !state_reg.dfe[`AFE_DFE_AUTO_BIT] |=> chanCtrl[0].gainCode == $past(state_reg.gain[5:0]))
        else $error("manual gain not applied");

    auto_keeps_a: assert property (
        state_reg.dfe[`AFE_DFE_AUTO_BIT] |=> chanCtrl[1].gainCode == $past(autoGainCode[1]))
        else $error("manual gain overrode auto gain");

    half_bw_a: assert property (
        ##1 chanCtrl[1].halfBw == $past(state_reg.ctl1[`AFE_CTL1_HALFBW_LSB + 1]))
        else $error("half bandwidth not following control");

    filter_bypass_a: assert property (
        ##1 chanCtrl[2].bypass == $past(state_reg.ctl3[`AFE_CTL3_BYPASS_LSB + 2]))
        else $error("bypass not following control");

    static_select_a: assert property (
        staticMode_s |-> adc2ChanSel == $past(state_reg.misc[`AFE_MISC_CHSEL_BIT]))
        else $error("static channel select wrong");

    dual_toggle_a: assert property (
        dualTick_s |=> adc2ChanSel != $past(adc2ChanSel))
        else $error("dual mode did not alternate");

    dual_hold_a: assert property (
        dualIdle_s |=> $stable(adc2ChanSel))
        else $error("dual mode moved without a sample");

    boost_follow_a: assert property (
        ##1 chanCtrl[0].boost == $past(state_reg.ctl1[`AFE_CTL1_BOOST_LSB]))
        else $error("boost not following control");

    manual_shared_a: assert property (
        !state_reg.dfe[`AFE_DFE_AUTO_BIT] |=> chanCtrl[2].gainCode == $past(state_reg.gain[5:0]))
        else $error("manual gain not shared by all channels");

    auto_each_a: assert property (
        state_reg.dfe[`AFE_DFE_AUTO_BIT] |=> chanCtrl[2].gainCode == $past(autoGainCode[2]))
        else $error("auto gain lost on a channel");

    dll_factor_a: assert property (
        dllMultFactor == 3'h5)
        else $error("sample clock multiplier not five");

endmodule

`default_nettype wire

/* File: verilog/afe_ctrl_defs.svh */
`ifndef AFE_CTRL_DEFS_SVH
`define AFE_CTRL_DEFS_SVH

// Register indexes; byte address is four times the index
`define AFE_IDX_MISC 14'h0102
`define AFE_IDX_CTL1 14'h0104
`define AFE_IDX_CTL3 14'h0106
`define AFE_IDX_GAIN 14'h0488
`define AFE_IDX_STATUS 14'h0489
`define AFE_IDX_DFE 14'h048b

// Field positions
`define AFE_MISC_DUAL_BIT 2
`define AFE_MISC_CHSEL_BIT 3
`define AFE_CTL1_BOOST_LSB 0
`define AFE_CTL1_HALFBW_LSB 3
`define AFE_CTL3_BYPASS_LSB 0
`define AFE_DFE_AUTO_BIT 0

// Writable bit masks, everything else reads zero
`define AFE_MISC_MASK 8'h0c
`define AFE_CTL1_MASK 8'h3f
`define AFE_CTL3_MASK 8'h07
`define AFE_GAIN_MASK 8'h3f
`define AFE_DFE_MASK 8'h01

// Reset values
`define AFE_MISC_RESET 8'h00
`define AFE_CTL1_RESET 8'h00
`define AFE_CTL3_RESET 8'h00
`define AFE_GAIN_RESET 8'h20
`define AFE_DFE_RESET 8'h01

// Gain arithmetic: linear gain in units of 1/64
`define AFE_FINE_BASE 10'h010
`define AFE_BOOST_SHIFT 2
`define AFE_DLL_MULT 3'h5

`endif

/* File: verilog/afe_ctrl_pkg.sv */
package afe_ctrl_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_MISC = 3'b001,
        SEL_CTL1 = 3'b010,
        SEL_CTL3 = 3'b011,
        SEL_GAIN = 3'b100,
        SEL_DFE = 3'b101,
        SEL_STATUS = 3'b110
    } reg_sel_t;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    // Controls handed to one analog channel
    typedef struct packed {
        logic boost;
        logic halfBw;
        logic bypass;
        logic [5:0] gainCode;
        logic [9:0] gainLinear;
    } chan_ctrl_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] misc;
        logic [7:0] ctl1;
        logic [7:0] ctl3;
        logic [7:0] gain;
        logic [7:0] dfe;
        logic awHeld;
        logic wHeld;
        logic [15:0] awAddr;
        logic [7:0] wByte;
        logic wLane;
        logic awReady;
        logic wReady;
        logic bValid;
        axi_resp_t bResp;
        logic arReady;
        logic rValid;
        axi_resp_t rResp;
        logic [31:0] rData;
        logic adc2Chan;
        chan_ctrl_t [2:0] chan;
        logic [2:0] dllMult;
    } afe_state_t;

endpackage

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "afe_ctrl_defs.svh"

module tb
    import afe_ctrl_pkg::*;
;
    // ----------------------------------------
    // Bench signals and register model
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, adc2ChanSel;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    logic [2:0][5:0] autoGainCode = '0;
    logic sampleTick = 1'b0;
    chan_ctrl_t [2:0] chanCtrl;
    logic [2:0] dllMultFactor;
    int failures = 0, totalChecks = 0;
    logic [15:0] regAddr [5];
    logic [7:0] regMask [5], regRst [5], mdl [5];
    logic expSel;

    afe_gain_filter_adc_control u_afe_gain_filter_adc_control (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .autoGainCode(autoGainCode), .sampleTick(sampleTick),
        .chanCtrl(chanCtrl), .adc2ChanSel(adc2ChanSel), .dllMultFactor(dllMultFactor)
    );

    // Free-running system clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Compare, bus and stimulus tasks
    // ----------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        logic awTaken, wTaken, bSeen;
        @(posedge clk_sys);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awaddr <= a;
        wdata <= {24'($urandom()), v};
        wstrb <= s;
        n = 0;
        do begin
            // Look between edges, where the slave's outputs have settled
            @(negedge clk_sys);
            awTaken = awvalid && awready === 1'b1;
            wTaken = wvalid && wready === 1'b1;
            bSeen = bvalid === 1'b1;
            r = bresp;
            @(posedge clk_sys);
            if (awTaken) awvalid <= 1'b0;
            if (wTaken) wvalid <= 1'b0;
            n++;
        end while (!bSeen && n < 50);
        bready <= 1'b0;
        if (n >= 50) failures++;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic arTaken, rSeen;
        @(posedge clk_sys);
        arvalid <= 1'b1;
        rready <= 1'b1;
        araddr <= a;
        n = 0;
        do begin
            @(negedge clk_sys);
            arTaken = arvalid && arready === 1'b1;
            rSeen = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (arTaken) arvalid <= 1'b0;
            n++;
        end while (!rSeen && n < 50);
        rready <= 1'b0;
        if (n >= 50) failures++;
    endtask

    // Masked write that keeps the model in step
    task automatic put(input int k, input logic [7:0] v);
        logic [1:0] r;
        wr(regAddr[k], v, 4'hf, r);
        chk_resp(r, RESP_OKAY);
        mdl[k] = v & regMask[k];
    endtask

    // Gain code, linear gain and filter controls of all three channels
    task automatic chk_chans();
        int code, lin;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            code = mdl[4][0] ? int'(autoGainCode[i]) : int'(mdl[3][5:0]);
            lin = (16 + (code & 15)) << (code >> 4);
            if (mdl[1][i]) lin = lin << 2;
            chk_val(chanCtrl[i].gainCode, code); // effective code
            chk_val(chanCtrl[i].gainLinear, lin); // linear gain
            chk_val(chanCtrl[i].boost, mdl[1][i]); // boost enable
            chk_val(chanCtrl[i].halfBw, mdl[1][3 + i]); // half bandwidth
            chk_val(chanCtrl[i].bypass, mdl[2][i]); // filter bypass
        end
    endtask

    // Sample pulses held for n back-to-back cycles
    task automatic tick(input int n);
        @(posedge clk_sys);
        sampleTick <= 1'b1;
        repeat (n) @(posedge clk_sys);
        sampleTick <= 1'b0;
        if (mdl[0][2]) expSel = expSel ^ n[0];
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        report_and_stop();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(32'h38d67978));
        regAddr = '{{`AFE_IDX_MISC, 2'b00}, {`AFE_IDX_CTL1, 2'b00}, {`AFE_IDX_CTL3, 2'b00},
                    {`AFE_IDX_GAIN, 2'b00}, {`AFE_IDX_DFE, 2'b00}};
        regMask = '{`AFE_MISC_MASK, `AFE_CTL1_MASK, `AFE_CTL3_MASK, `AFE_GAIN_MASK,
                    `AFE_DFE_MASK};
        regRst = '{`AFE_MISC_RESET, `AFE_CTL1_RESET, `AFE_CTL3_RESET, `AFE_GAIN_RESET,
                   `AFE_DFE_RESET};
        mdl = regRst;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Reset values, then random read-back through the masks
        for (int k = 0; k < 15; k++) begin
            if (k >= 5) put(k % 5, 8'($urandom()));
            rd(regAddr[k % 5], d, r);
            chk_val(d, {24'h0, mdl[k % 5]}); // reset or written value
        end
        chk_val(dllMultFactor, 5); // five times crystal
        // Unmapped, unaligned and byte-lane-0-unstrobed accesses change nothing
        rd(16'h0004, d, r);
        chk_resp(r, RESP_SLVERR);
        chk_val(d, 0);
        wr(regAddr[3] + 16'h1, 8'h3f, 4'hf, r);
        chk_resp(r, RESP_SLVERR);
        wr(regAddr[3], 8'h15, 4'he, r);
        chk_resp(r, RESP_OKAY);
        rd(regAddr[3], d, r);
        chk_val(d, {24'h0, mdl[3]});
        // Manual gain over every code with random boost and filter bits
        put(4, 8'h00); // auto gain off
        for (int g = 0; g < 64; g++) begin
            put(1, 8'($urandom()));
            put(2, 8'($urandom()));
            put(3, 8'(g) | 8'hc0);
            chk_chans();
        end
        // Auto gain wins over stored manual codes
        put(4, 8'h01);
        for (int k = 0; k < 4; k++) begin
            autoGainCode <= {6'($urandom()), 6'($urandom()), 6'($urandom())};
            put(3, 8'($urandom()));
            chk_chans();
            rd(regAddr[3], d, r);
            chk_val(d, {24'h0, mdl[3]}); // stored while auto
        end
        put(4, 8'h00);
        chk_chans();
        // Static channel choice ignores sample pulses
        for (int s = 0; s < 2; s++) begin
            put(0, 8'($urandom() & 32'hf3) | 8'(s << 3));
            expSel = s[0];
            tick(1 + s);
            chk_val(adc2ChanSel, expSel); // static channel
        end
        // Alternating mode flips once per sample and holds between them
        put(0, 8'h0c);
        for (int n = 1; n < 7; n++) begin
            tick(n);
            repeat (n) @(posedge clk_sys);
            chk_val(adc2ChanSel, expSel); // alternate per sample
        end
        // Status mirrors dual mode, current channel and channel 0 code; writes ignored
        wr({`AFE_IDX_STATUS, 2'b00}, 8'hff, 4'hf, r);
        chk_resp(r, RESP_OKAY);
        rd({`AFE_IDX_STATUS, 2'b00}, d, r);
        chk_resp(r, RESP_OKAY);
        chk_val(d, {24'h0, mdl[0][2], expSel, mdl[3][5:0]}); // live routing
        report_and_stop();
    end
endmodule
`default_nettype wire
